/* File: design/dtio_pkg.sv */
// Package with register map, reset values and timing constants of the terminal block
package dtio_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_DELAY1   = 8'h00;
  localparam logic [7:0] REG_DELAY2   = 8'h04;
  localparam logic [7:0] REG_DELAY3   = 8'h08;
  localparam logic [7:0] REG_POL_A    = 8'h0c;
  localparam logic [7:0] REG_POL_B    = 8'h10;
  localparam logic [7:0] REG_FAST_MD  = 8'h14;
  localparam logic [7:0] REG_FN_BRLY  = 8'h18;
  localparam logic [7:0] REG_FN_XRLY  = 8'h1c;
  localparam logic [7:0] REG_FN_OC1   = 8'h20;
  localparam logic [7:0] REG_FN_OC2   = 8'h24;
  localparam logic [7:0] REG_FN_FAST  = 8'h28;
  localparam logic [7:0] REG_CNT_TGT  = 8'h2c;
  localparam logic [7:0] REG_IN_STAT  = 8'h30;
  localparam logic [7:0] REG_OUT_STAT = 8'h34;
  localparam logic [7:0] REG_IRQ_STAT = 8'h38;
  localparam logic [7:0] REG_IRQ_MASK = 8'h3c;

  // Widths
  localparam int NUM_IN    = 10;
  localparam int NUM_DLY   = 3;
  localparam int DLY_W     = 16;
  localparam int POL_W     = 17;
  localparam int FN_W      = 5;
  localparam int DIGITS    = 5;

  // Delay in tenths of a second, range limit and reset
  localparam logic [DLY_W-1:0] DELAY_MAX   = 16'd36000;
  localparam logic [DLY_W-1:0] DELAY_RESET = 16'h0000;
  // Polarity words, decimal digits, units digit is lowest terminal
  localparam logic [POL_W-1:0] POL_RESET   = 17'h00000;
  localparam logic [3:0]       POL_LOW_ACT = 4'h1;

  // Fast terminal mode codes
  localparam logic FAST_MODE_PULSE  = 1'b0;
  localparam logic FAST_MODE_SWITCH = 1'b1;

  // Output function codes
  localparam logic [FN_W-1:0] FN_NONE      = 5'h00;
  localparam logic [FN_W-1:0] FN_RUNNING   = 5'h01;
  localparam logic [FN_W-1:0] FN_FAULT     = 5'h02;
  localparam logic [FN_W-1:0] FN_FREQ_LVL1 = 5'h03;
  localparam logic [FN_W-1:0] FN_FREQ_REACH= 5'h04;
  localparam logic [FN_W-1:0] FN_ZERO_RUN  = 5'h05;
  localparam logic [FN_W-1:0] FN_MOTOR_OVL = 5'h06;
  localparam logic [FN_W-1:0] FN_DRIVE_OVL = 5'h07;
  localparam logic [FN_W-1:0] FN_CNT_REACH = 5'h08;

  // Selector reset values
  localparam logic [FN_W-1:0] FN_BRLY_RESET = 5'h02;
  localparam logic [FN_W-1:0] FN_XRLY_RESET = 5'h00;
  localparam logic [FN_W-1:0] FN_OC1_RESET  = 5'h00;
  localparam logic [FN_W-1:0] FN_OC2_RESET  = 5'h04;
  localparam logic [FN_W-1:0] FN_FAST_RESET = 5'h00;

  // Drive overload warning lead time, in seconds and in tenths of a second
  localparam real              OVL_LEAD_S   = 10.0;
  localparam logic [DLY_W-1:0] OVL_LEAD_DS  = 16'd100;

  // Delay step and clock
  localparam real CLK_HZ       = 20.0e6;
  localparam real DELAY_STEP_S = 0.1;
  localparam int  STEP_CYCLES  = int'(DELAY_STEP_S * CLK_HZ);
endpackage

/* File: design/dtio_terminal.sv */
// Terminal conditioning and output routing logic with APB register access
//Contract
//- Inputs one to three get 0-3600.0 s delay
//- Only inputs one to three are delayed
//- Polarity digit 0 high active, 1 low
//- Two five-digit polarity words, units digit first
//- High active: closed contact means asserted
//- Fast terminal mode 0 pulse, 1 switch
//- Per-output selectors, defaults 2, 0, 0, 4, 0
//- Code 0 keeps output inactive
//- Code 1 on while drive running
//- Code 2 on at fault stop
//- Codes 3, 4 route level detect, reached
//- Code 5 on at zero-speed run only
//- Code 6 on at motor overload pre-warning
//- Code 7 on 10 s before overload
//- Code 8 on when count reaches target
`timescale 1ns/1ps
module dtio_terminal #(
  parameter int STEP_CYCLES = dtio_pkg::STEP_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [9:0]  switch_closed,
  input  wire logic        drive_running,
  input  wire logic        fault_stop,
  input  wire logic        zero_frequency,
  input  wire logic        frequency_level_detect_1,
  input  wire logic        frequency_reached,
  input  wire logic        motor_overload_prewarn,
  input  wire logic        overload_eta_valid,
  input  wire logic [15:0] overload_eta_ds,
  input  wire logic [31:0] count_value,
  input  wire logic        fast_pulse_in,
  output logic      [9:0]  switch_asserted,
  output logic             board_relay_contacts,
  output logic             extension_relay_contacts,
  output logic             open_collector_out_1,
  output logic             open_collector_out_2,
  output logic             fast_multi_output
);

  localparam int NI = dtio_pkg::NUM_IN;
  localparam int ND = dtio_pkg::NUM_DLY;
  localparam int DW = dtio_pkg::DLY_W;
  localparam int FW = dtio_pkg::FN_W;
  localparam int PW = dtio_pkg::POL_W;

  logic [DW-1:0]   delay_q [ND];
  logic [PW-1:0]   pol_a_q;
  logic [PW-1:0]   pol_b_q;
  logic            fast_mode_q;
  logic [FW-1:0]   fn_brly_q;
  logic [FW-1:0]   fn_xrly_q;
  logic [FW-1:0]   fn_oc1_q;
  logic [FW-1:0]   fn_oc2_q;
  logic [FW-1:0]   fn_fast_q;
  logic [31:0]     cnt_tgt_q;
  logic [NI-1:0]   irq_stat_q;
  logic [NI-1:0]   irq_mask_q;
  logic [31:0]     step_cnt_q;
  logic            step_tick;
  logic [NI-1:0]   low_active;
  logic [NI-1:0]   level_in;
  logic [NI-1:0]   level_prev_q;
  logic [DW-1:0]   hold_cnt_q [ND];
  logic [NI-1:0]   cond_d;
  logic [NI-1:0]   in_change;
  logic            wr_en;
  logic            rd_en;
  logic            addr_ok;
  logic [31:0]     rd_mux;

  // Decimal digit of a polarity word selects low-active sense
  function automatic logic digit_low(input logic [PW-1:0] word, input int pos);
    logic [PW-1:0] v;
    v = word;
    for (int k = 0; k < pos; k++)
    begin
      v = PW'(v / PW'(10));
    end
    return PW'(v % PW'(10)) == PW'(dtio_pkg::POL_LOW_ACT);
  endfunction

  // Condition selected by an output function code
  function automatic logic fn_value(input logic [FW-1:0] code);
    case (code)
      dtio_pkg::FN_NONE:       fn_value = 1'b0;
      dtio_pkg::FN_RUNNING:    fn_value = drive_running;
      dtio_pkg::FN_FAULT:      fn_value = fault_stop;
      dtio_pkg::FN_FREQ_LVL1:  fn_value = frequency_level_detect_1;
      dtio_pkg::FN_FREQ_REACH: fn_value = frequency_reached;
      dtio_pkg::FN_ZERO_RUN:   fn_value = drive_running & zero_frequency;
      dtio_pkg::FN_MOTOR_OVL:  fn_value = motor_overload_prewarn;
      dtio_pkg::FN_DRIVE_OVL:  fn_value = overload_eta_valid &
                                          (overload_eta_ds <= dtio_pkg::OVL_LEAD_DS);
      dtio_pkg::FN_CNT_REACH:  fn_value = count_value >= cnt_tgt_q;
      default:                 fn_value = 1'b0;
    endcase
  endfunction

  // Clamp of a delay write to the allowed range
  function automatic logic [DW-1:0] clamp_delay(input logic [31:0] v);
    return (v > 32'(dtio_pkg::DELAY_MAX)) ? dtio_pkg::DELAY_MAX : DW'(v);
  endfunction

  // APB decode
  assign wr_en = psel & penable & pwrite & ~pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= dtio_pkg::REG_IRQ_MASK);

  // Polarity per terminal and asserted level
  always_comb
  begin
    for (int i = 0; i < NI; i++)
    begin
      low_active[i] = (i < 5) ? digit_low(pol_a_q, i) : digit_low(pol_b_q, i - 5);
      level_in[i] = switch_closed[i] ^ low_active[i];
    end
  end

  // Base tick of one delay step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_cnt_q <= 32'h00000000;
    end
    else if (step_tick)
    begin
      step_cnt_q <= 32'h00000000;
    end
    else
    begin
      step_cnt_q <= step_cnt_q + 32'h00000001;
    end
  end
  assign step_tick = (step_cnt_q >= 32'(STEP_CYCLES - 1));

  // Change delay counters on the first three inputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_prev_q <= '0;
      for (int i = 0; i < ND; i++)
      begin
        hold_cnt_q[i] <= DW'(0);
      end
    end
    else
    begin
      level_prev_q <= level_in;
      for (int i = 0; i < ND; i++)
      begin
        if (level_in[i] != level_prev_q[i])
        begin
          hold_cnt_q[i] <= DW'(0);
        end
        else if (step_tick && hold_cnt_q[i] < delay_q[i])
        begin
          hold_cnt_q[i] <= hold_cnt_q[i] + DW'(1);
        end
      end
    end
  end

  // Next conditioned state
  always_comb
  begin
    cond_d = switch_asserted;
    for (int i = 0; i < NI; i++)
    begin
      if (i < ND)
      begin
        if (level_in[i] == level_prev_q[i] && hold_cnt_q[i] >= delay_q[i])
        begin
          cond_d[i] = level_in[i];
        end
      end
      else
      begin
        cond_d[i] = level_in[i];
      end
    end
  end
  assign in_change = cond_d ^ switch_asserted;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      switch_asserted <= '0;
    end
    else
    begin
      switch_asserted <= cond_d;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < ND; i++)
      begin
        delay_q[i] <= dtio_pkg::DELAY_RESET;
      end
      pol_a_q     <= dtio_pkg::POL_RESET;
      pol_b_q     <= dtio_pkg::POL_RESET;
      fast_mode_q <= dtio_pkg::FAST_MODE_PULSE;
      fn_brly_q   <= dtio_pkg::FN_BRLY_RESET;
      fn_xrly_q   <= dtio_pkg::FN_XRLY_RESET;
      fn_oc1_q    <= dtio_pkg::FN_OC1_RESET;
      fn_oc2_q    <= dtio_pkg::FN_OC2_RESET;
      fn_fast_q   <= dtio_pkg::FN_FAST_RESET;
      cnt_tgt_q   <= 32'h00000000;
      irq_mask_q  <= '0;
    end
    else if (wr_en)
    begin
      case (paddr)
        dtio_pkg::REG_DELAY1:   delay_q[0]  <= clamp_delay(pwdata);
        dtio_pkg::REG_DELAY2:   delay_q[1]  <= clamp_delay(pwdata);
        dtio_pkg::REG_DELAY3:   delay_q[2]  <= clamp_delay(pwdata);
        dtio_pkg::REG_POL_A:    pol_a_q     <= pwdata[PW-1:0];
        dtio_pkg::REG_POL_B:    pol_b_q     <= pwdata[PW-1:0];
        dtio_pkg::REG_FAST_MD:  fast_mode_q <= pwdata[0];
        dtio_pkg::REG_FN_BRLY:  fn_brly_q   <= pwdata[FW-1:0];
        dtio_pkg::REG_FN_XRLY:  fn_xrly_q   <= pwdata[FW-1:0];
        dtio_pkg::REG_FN_OC1:   fn_oc1_q    <= pwdata[FW-1:0];
        dtio_pkg::REG_FN_OC2:   fn_oc2_q    <= pwdata[FW-1:0];
        dtio_pkg::REG_FN_FAST:  fn_fast_q   <= pwdata[FW-1:0];
        dtio_pkg::REG_CNT_TGT:  cnt_tgt_q   <= pwdata;
        dtio_pkg::REG_IRQ_MASK: irq_mask_q  <= pwdata[NI-1:0];
        default:                cnt_tgt_q   <= cnt_tgt_q;
      endcase
    end
  end

  // Sticky input-change events, new event wins over a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q <= '0;
    end
    else
    begin
      if (wr_en && paddr == dtio_pkg::REG_IRQ_STAT)
      begin
        irq_stat_q <= (irq_stat_q & ~pwdata[NI-1:0]) | in_change;
      end
      else
      begin
        irq_stat_q <= irq_stat_q | in_change;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Output routing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      board_relay_contacts     <= 1'b0;
      extension_relay_contacts <= 1'b0;
      open_collector_out_1     <= 1'b0;
      open_collector_out_2     <= 1'b0;
      fast_multi_output        <= 1'b0;
    end
    else
    begin
      board_relay_contacts     <= fn_value(fn_brly_q);
      extension_relay_contacts <= fn_value(fn_xrly_q);
      open_collector_out_1     <= fn_value(fn_oc1_q);
      open_collector_out_2     <= fn_value(fn_oc2_q);
      fast_multi_output        <= (fast_mode_q == dtio_pkg::FAST_MODE_SWITCH) ?
                                  fn_value(fn_fast_q) : fast_pulse_in;
    end
  end

  // Read multiplexer
  always_comb
  begin
    case (paddr)
      dtio_pkg::REG_DELAY1:   rd_mux = 32'(delay_q[0]);
      dtio_pkg::REG_DELAY2:   rd_mux = 32'(delay_q[1]);
      dtio_pkg::REG_DELAY3:   rd_mux = 32'(delay_q[2]);
      dtio_pkg::REG_POL_A:    rd_mux = 32'(pol_a_q);
      dtio_pkg::REG_POL_B:    rd_mux = 32'(pol_b_q);
      dtio_pkg::REG_FAST_MD:  rd_mux = 32'(fast_mode_q);
      dtio_pkg::REG_FN_BRLY:  rd_mux = 32'(fn_brly_q);
      dtio_pkg::REG_FN_XRLY:  rd_mux = 32'(fn_xrly_q);
      dtio_pkg::REG_FN_OC1:   rd_mux = 32'(fn_oc1_q);
      dtio_pkg::REG_FN_OC2:   rd_mux = 32'(fn_oc2_q);
      dtio_pkg::REG_FN_FAST:  rd_mux = 32'(fn_fast_q);
      dtio_pkg::REG_CNT_TGT:  rd_mux = cnt_tgt_q;
      dtio_pkg::REG_IN_STAT:  rd_mux = 32'(switch_asserted);
      dtio_pkg::REG_OUT_STAT: rd_mux = {27'h0000000, fast_multi_output, open_collector_out_2,
                                        open_collector_out_1, extension_relay_contacts,
                                        board_relay_contacts};
      dtio_pkg::REG_IRQ_STAT: rd_mux = 32'(irq_stat_q);
      dtio_pkg::REG_IRQ_MASK: rd_mux = 32'(irq_mask_q);
      default:                rd_mux = 32'h00000000;
    endcase
  end

  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      prdata  <= (rd_en && addr_ok) ? rd_mux : 32'h00000000;
    end
  end

endmodule // dtio_terminal

/* File: verification/dtio_monitor.sv */
// Checker of the terminal block port behaviour
`timescale 1ns/1ps
module dtio_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic [9:0]  switch_closed,
  input wire logic [9:0]  switch_asserted
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [9:0] seen_q;
  logic [2:0] quiet_q;
  // Edges since the last bus access or input event
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      seen_q  <= '0;
      quiet_q <= '0;
    end
    else
    begin
      seen_q <= switch_asserted;
      if (psel || switch_asserted != seen_q)
        quiet_q <= '0;
      else if (quiet_q != 3'h7)
        quiet_q <= quiet_q + 3'h1;
    end
  access_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase without answer");
  answer_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access phase");
  error_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  plain_input_a: assert property ($past(presetn) && !$past(psel) |=>
    ((switch_asserted[9:3] ^ $past(switch_asserted[9:3])) == ($past(switch_closed[9:3]) ^ $past(switch_closed[9:3], 2))))
    else $error("undelayed input did not follow its contact");
  irq_cause_a: assert property ($changed(irq) |-> quiet_q < 3'h4)
    else $error("interrupt moved without a cause");
  reset_clear_a: assert property (!$past(presetn) |-> switch_asserted == 10'h0 && !irq)
    else $error("outputs not clear after reset");
endmodule // dtio_monitor

/* File: verification/dtio_field_model.sv */
// Field side model: switch contacts and output loads
`timescale 1ns/1ps
module dtio_field_model (
  input  wire logic       pclk,
  input  wire logic [9:0] contact_cmd,
  input  wire logic [4:0] load_drive,
  output logic      [9:0] switch_closed,
  output logic      [4:0] load_on
);
  initial
  begin
    switch_closed = '0;
    load_on       = '0;
  end
  // Contacts move and loads settle one edge after the command
  always @(posedge pclk)
  begin
    switch_closed <= contact_cmd;
    load_on       <= load_drive;
  end
endmodule // dtio_field_model

/* File: verification/tb_top.sv */
// Top bench of the terminal block: APB tasks and directed tests
`timescale 1ns/1ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, cnt;
  logic [9:0]  contact_cmd, switch_closed, switch_asserted;
  logic        run, flt, zf, lvl, rch, pre, eta_v, fpi;
  logic [15:0] eta;
  wire logic [4:0] drv;
  logic [4:0]  load_on;
  int          fail_count = 0;
  int          total_checks = 0;
  dtio_terminal #(.STEP_CYCLES(4)) dtio_terminal_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .switch_closed, .drive_running(run), .fault_stop(flt), .zero_frequency(zf),
    .frequency_level_detect_1(lvl), .frequency_reached(rch), .motor_overload_prewarn(pre),
    .overload_eta_valid(eta_v), .overload_eta_ds(eta), .count_value(cnt), .fast_pulse_in(fpi),
    .switch_asserted, .board_relay_contacts(drv[0]), .extension_relay_contacts(drv[1]),
    .open_collector_out_1(drv[2]), .open_collector_out_2(drv[3]), .fast_multi_output(drv[4]));
  dtio_field_model dtio_field_model_i (.pclk, .contact_cmd, .load_drive(drv), .switch_closed, .load_on);
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic summarize;
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #1ms;
    fail_count++;
    summarize();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, contact_cmd, run, flt, zf, lvl, rch, pre, eta_v, fpi, eta, cnt} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++)
      rdchk(8'(i * 4), (i == 6) ? 32'h2 : (i == 9) ? 32'h4 : 32'h0, "reset value");
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    // Low active digits on inputs 1, 3, 5, 9 and 10, all contacts closed
    contact_cmd <= 10'h3ff;
    apb(1'b1, dtio_pkg::REG_POL_A, 32'd10101);
    apb(1'b1, dtio_pkg::REG_POL_B, 32'd11000);
    cyc(4);
    rdchk(dtio_pkg::REG_IN_STAT, 32'h0ea, "input state");
    apb(1'b1, dtio_pkg::REG_POL_A, 32'h0);
    apb(1'b1, dtio_pkg::REG_POL_B, 32'h0);
    apb(1'b1, dtio_pkg::REG_DELAY1, 32'd3);
    cyc(4);
    contact_cmd <= 10'h000;
    cyc(4);
    chk("undelayed inputs", 32'(switch_asserted), 32'h001);
    for (int i = 0; i < 3; i++)
    begin
      contact_cmd <= 10'h001;
      cyc(8);
      contact_cmd <= 10'h000;
      cyc(8);
      chk("bouncing input 1", 32'(switch_asserted[0]), 32'h1);
    end
    cyc(20);
    chk("delayed input 1", 32'(switch_asserted[0]), 32'h0);
    apb(1'b1, dtio_pkg::REG_DELAY2, 32'd40000);
    rdchk(dtio_pkg::REG_DELAY2, 32'd36000, "delay limit");
    // Every code with all conditions on, then off with zero frequency kept and overload estimate moved from 100 to 101
    apb(1'b1, dtio_pkg::REG_CNT_TGT, 32'd5);
    for (int v = 1; v >= 0; v--)
      for (int c = 0; c < 11; c++)
      begin
        {run, flt, lvl, rch, pre} <= {5{v[0]}};
        eta_v <= 1'b1;
        zf  <= 1'b1;
        eta <= v ? 16'd100 : 16'd101;
        cnt <= v ? 32'd5 : 32'd4;
        apb(1'b1, dtio_pkg::REG_FN_XRLY, (c == 10) ? 32'd31 : 32'(c));
        cyc(3);
        chk("extension relay", 32'(load_on[1]), 32'(v == 1 && c > 0 && c < 9));
        chk("default outputs", 32'(load_on & 5'h0d), v ? 32'h9 : 32'h0);
      end
    apb(1'b1, dtio_pkg::REG_FN_FAST, 32'h1);
    for (int m = 0; m < 4; m++)
    begin
      if (m == 2)
        apb(1'b1, dtio_pkg::REG_FAST_MD, 32'h1);
      fpi <= m[0] ^ m[1];
      run <= m[0];
      cyc(3);
      chk("fast output", 32'(load_on[4]), 32'(m[0]));
    end
    apb(1'b1, dtio_pkg::REG_FN_OC1, 32'h1);
    rdchk(dtio_pkg::REG_OUT_STAT, 32'h014, "output state");
    apb(1'b1, dtio_pkg::REG_IRQ_MASK, 32'h0);
    apb(1'b1, dtio_pkg::REG_IRQ_STAT, 32'h3ff);
    contact_cmd <= 10'h010;
    cyc(4);
    chk("masked irq", 32'(irq), 32'h0);
    rdchk(dtio_pkg::REG_IRQ_STAT, 32'h010, "irq status");
    apb(1'b1, dtio_pkg::REG_IRQ_MASK, 32'h010);
    cyc(2);
    chk("unmasked irq", 32'(irq), 32'h1);
    apb(1'b1, dtio_pkg::REG_IRQ_STAT, 32'h010);
    cyc(2);
    chk("cleared irq", 32'(irq), 32'h0);
    rdchk(dtio_pkg::REG_IRQ_STAT, 32'h0, "cleared status");
    summarize();
  end
endmodule // tb_top
bind dtio_terminal dtio_monitor dtio_monitor_i (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr, .irq,
  .switch_closed, .switch_asserted);
